// file: core/cap_gate.sv
// Per-channel gate that merges several masked alarm types into one polling set request.
`timescale 1ns/10ps
`default_nettype none
module cap_gate
  import cap_pkg::*;
#(
  parameter int N_TYPES = 1
) (
  input wire logic [N_TYPES-1:0][NUM_CH-1:0] evt,
  input wire logic [N_TYPES-1:0] mask,
  output logic [NUM_CH-1:0] set
);

  // A cleared mask bit blocks its alarm type for every channel at once.
  function automatic logic [NUM_CH-1:0] gate_types(
    input logic [N_TYPES-1:0][NUM_CH-1:0] e,
    input logic [N_TYPES-1:0] m
  );
    logic [NUM_CH-1:0] acc;
    acc = '0;
    for (int t = 0; t < N_TYPES; t++) begin
      acc = acc | (e[t] & {NUM_CH{m[t]}});
    end
    return acc;
  endfunction : gate_types

  always_comb begin
    set = gate_types(evt, mask);
  end

endmodule : cap_gate
`default_nettype wire

// file: core/cap_pkg.sv
// Constants, register map and carrier types of the channel alarm polling mask block.
// How it works
// - Drop mask bit 4 lets a desync FIFO error set the drop polling bit.
// - Drop mask bit 3 lets a pointer-byte AIS alarm set the drop polling bit.
// - Drop mask bit 2 lets a loss-of-pointer alarm set the drop polling bit.
// - Drop mask bit 1 lets a new data flag set the drop polling bit.
// - Drop mask bit 0 lets a size mismatch set the drop polling bit.
// - Add mask bit 6 lets transmit line AIS set the add polling bit.
// - Add mask bit 5 lets a transmit FIFO alarm set the add polling bit.
// - Add mask bit 4 lets PRBS out-of-lock set that channel's PRBS polling bit.
// - Add mask bit 3 lets transmit loss of signal set the add polling bit.
// - Add mask bit 2 lets transmit loss of clock set the add polling bit.
// - Add mask bit 1 lets a path trace mismatch set the drop polling bit.
// - Add mask bit 0 lets path trace loss of lock set the drop polling bit.
// - Interrupt asserts only with global enable set and the indication's mask bit set.
// - Per-channel add mask gates add alarms into the add flag; bit 7 is channel 8.
package cap_pkg;

  localparam int NUM_CH = 8;
  localparam int ADDR_W = 14;

  // Register indices; the byte address is four times the index.
  localparam logic [11:0] IDX_GLOBAL_EN = 12'h005;
  localparam logic [11:0] IDX_ADD_MASK = 12'h009;
  localparam logic [11:0] IDX_CH_ADD_MASK = 12'h03F;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h0C0;
  localparam logic [11:0] IDX_IRQ_CLEAR = 12'h0C1;
  localparam logic [11:0] IDX_DROP_MASK = 12'h800;

  // Drop mask register fields.
  localparam int DROP_FIFO_BIT = 4;
  localparam int DROP_AIS_BIT = 3;
  localparam int DROP_LOP_BIT = 2;
  localparam int DROP_NDF_BIT = 1;
  localparam int DROP_SIZE_BIT = 0;

  // Add and trace mask register fields.
  localparam int ADD_TX_AIS_BIT = 6;
  localparam int ADD_TX_FIFO_BIT = 5;
  localparam int ADD_PRBS_BIT = 4;
  localparam int ADD_TX_LOS_BIT = 3;
  localparam int ADD_TX_LOC_BIT = 2;
  localparam int ADD_J2_TIM_BIT = 1;
  localparam int ADD_J2_LOL_BIT = 0;

  // Global enable register and interrupt status/clear layout.
  localparam int GEN_IRQ_EN_BIT = 7;
  localparam int GIND_DROP_A_BUS_BIT = 5;
  localparam int GIND_DROP_B_BUS_BIT = 4;
  localparam int GIND_ADD_BUS_BIT = 3;
  localparam int GIND_DROP_A_CHAN_BIT = 2;
  localparam int GIND_DROP_B_CHAN_BIT = 1;
  localparam int GIND_ADD_CHAN_BIT = 0;

  localparam logic [7:0] DROP_MASK_VALID = 8'h1F;
  localparam logic [7:0] ADD_MASK_VALID = 8'h7F;
  localparam logic [7:0] GLOBAL_EN_VALID = 8'hBF;
  localparam logic [7:0] STATUS_VALID = 8'h3F;

  localparam logic [7:0] DROP_MASK_RESET = 8'h00;
  localparam logic [7:0] ADD_MASK_RESET = 8'h00;
  localparam logic [7:0] CH_ADD_MASK_RESET = 8'h00;
  localparam logic [7:0] GLOBAL_EN_RESET = 8'h00;
  localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;

  typedef enum logic [2:0] {
    REG_NONE = 3'h0,
    REG_GLOBAL_EN = 3'h1,
    REG_ADD_MASK = 3'h3,
    REG_CH_ADD_MASK = 3'h2,
    REG_IRQ_STATUS = 3'h6,
    REG_IRQ_CLEAR = 3'h7,
    REG_DROP_MASK = 3'h5
  } cap_reg_t;

  // Latched-alarm set events, one bit per channel, bit 7 is channel 8.
  typedef struct packed {
    logic [NUM_CH-1:0] desync_fifo_err;
    logic [NUM_CH-1:0] pointer_ais;
    logic [NUM_CH-1:0] pointer_loss;
    logic [NUM_CH-1:0] new_data_flag;
    logic [NUM_CH-1:0] size_mismatch;
    logic [NUM_CH-1:0] path_trace_mismatch;
    logic [NUM_CH-1:0] path_trace_unlock;
  } cap_drop_evt_t;

  typedef struct packed {
    logic [NUM_CH-1:0] tx_line_ais;
    logic [NUM_CH-1:0] tx_fifo_err;
    logic [NUM_CH-1:0] tx_signal_loss;
    logic [NUM_CH-1:0] tx_clock_loss;
  } cap_add_evt_t;

  // Global indications raised elsewhere in the device.
  typedef struct packed {
    logic drop_a_bus;
    logic drop_b_bus;
    logic add_bus;
    logic drop_a_chan;
    logic drop_b_chan;
  } cap_gind_t;

  typedef struct packed {
    logic [NUM_CH-1:0] drop_set;
    logic [NUM_CH-1:0] add_set;
    logic [NUM_CH-1:0] prbs_set;
  } cap_poll_t;

  typedef struct packed {
    logic [7:0] drop_mask;
    logic [7:0] add_mask;
    logic [7:0] ch_add_mask;
    logic [7:0] global_en;
    logic [7:0] irq_status;
    cap_poll_t poll;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } cap_state_t;

  localparam cap_state_t STATE_RESET = '{
    drop_mask: DROP_MASK_RESET,
    add_mask: ADD_MASK_RESET,
    ch_add_mask: CH_ADD_MASK_RESET,
    global_en: GLOBAL_EN_RESET,
    irq_status: IRQ_STATUS_RESET,
    poll: '0,
    prdata: 32'h0000_0000,
    pready: 1'b0,
    pslverr: 1'b0,
    irq: 1'b0
  };

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
    return {idx, 2'b00};
  endfunction : byte_addr

endpackage : cap_pkg

// file: core/cap_top.sv
// APB-controlled global alarm masks feeding channel polling bits and the interrupt output.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module cap_top
  import cap_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire cap_drop_evt_t DROP_EVT,
  input wire cap_add_evt_t ADD_EVT,
  input wire logic [NUM_CH-1:0] PRBS_UNLOCK_EVT,
  input wire cap_gind_t GLOBAL_IND,
  output cap_poll_t POLL_SET,
  output logic IRQ
);

  cap_state_t s_r;
  cap_state_t s_nxt;

  logic [6:0][NUM_CH-1:0] drop_evt_vec;
  logic [6:0] drop_gate_mask;
  logic [NUM_CH-1:0] drop_set;
  logic [3:0][NUM_CH-1:0] add_evt_vec;
  logic [3:0] add_gate_mask;
  logic [NUM_CH-1:0] add_set;
  logic [0:0][NUM_CH-1:0] prbs_evt_vec;
  logic [0:0] prbs_gate_mask;
  logic [NUM_CH-1:0] prbs_set;

  // Address decode shared by the read in setup and the write in access.
  function automatic cap_reg_t decode(input logic [ADDR_W-1:0] a);
    cap_reg_t r;
    r = REG_NONE;
    if (a == byte_addr(IDX_GLOBAL_EN)) begin
      r = REG_GLOBAL_EN;
    end else if (a == byte_addr(IDX_ADD_MASK)) begin
      r = REG_ADD_MASK;
    end else if (a == byte_addr(IDX_CH_ADD_MASK)) begin
      r = REG_CH_ADD_MASK;
    end else if (a == byte_addr(IDX_IRQ_STATUS)) begin
      r = REG_IRQ_STATUS;
    end else if (a == byte_addr(IDX_IRQ_CLEAR)) begin
      r = REG_IRQ_CLEAR;
    end else if (a == byte_addr(IDX_DROP_MASK)) begin
      r = REG_DROP_MASK;
    end
    return r;
  endfunction : decode

  // Drop side: pointer and payload alarms plus both path trace alarms.
  always_comb begin
    drop_evt_vec = {DROP_EVT.desync_fifo_err, DROP_EVT.pointer_ais, DROP_EVT.pointer_loss,
                    DROP_EVT.new_data_flag, DROP_EVT.size_mismatch,
                    DROP_EVT.path_trace_mismatch, DROP_EVT.path_trace_unlock};
    drop_gate_mask = {s_r.drop_mask[DROP_FIFO_BIT],
                      s_r.drop_mask[DROP_AIS_BIT],
                      s_r.drop_mask[DROP_LOP_BIT],
                      s_r.drop_mask[DROP_NDF_BIT],
                      s_r.drop_mask[DROP_SIZE_BIT],
                      s_r.add_mask[ADD_J2_TIM_BIT],
                      s_r.add_mask[ADD_J2_LOL_BIT]};
    add_evt_vec = {ADD_EVT.tx_line_ais, ADD_EVT.tx_fifo_err,
                   ADD_EVT.tx_signal_loss, ADD_EVT.tx_clock_loss};
    add_gate_mask = {s_r.add_mask[ADD_TX_AIS_BIT],
                     s_r.add_mask[ADD_TX_FIFO_BIT],
                     s_r.add_mask[ADD_TX_LOS_BIT],
                     s_r.add_mask[ADD_TX_LOC_BIT]};
    prbs_evt_vec = PRBS_UNLOCK_EVT;
    prbs_gate_mask = s_r.add_mask[ADD_PRBS_BIT];
  end

  // The events arrive unchanged from the alarm latches; only the polling path is gated.
  cap_gate #(
    .N_TYPES(7)
  ) u_drop_gate (
    .evt(drop_evt_vec),
    .mask(drop_gate_mask),
    .set(drop_set)
  );

  cap_gate #(
    .N_TYPES(4)
  ) u_add_gate (
    .evt(add_evt_vec),
    .mask(add_gate_mask),
    .set(add_set)
  );

  cap_gate #(
    .N_TYPES(1)
  ) u_prbs_gate (
    .evt(prbs_evt_vec),
    .mask(prbs_gate_mask),
    .set(prbs_set)
  );

  always_comb begin
    cap_reg_t sel;
    logic setup;
    logic access;
    logic [7:0] rd;
    logic [7:0] clr;
    logic [7:0] ev;
    sel = decode(PADDR);
    setup = PSEL & ~PENABLE;
    access = PSEL & PENABLE & s_r.pready;
    rd = 8'h00;
    clr = 8'h00;
    ev = 8'h00;
    s_nxt = s_r;

    // Setup cycle: answer is prepared so PREADY is high in the first access cycle.
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    if (setup) begin
      if (sel == REG_GLOBAL_EN) begin
        rd = s_r.global_en;
      end else if (sel == REG_ADD_MASK) begin
        rd = s_r.add_mask;
      end else if (sel == REG_CH_ADD_MASK) begin
        rd = s_r.ch_add_mask;
      end else if (sel == REG_IRQ_STATUS) begin
        rd = s_r.irq_status;
      end else if (sel == REG_DROP_MASK) begin
        rd = s_r.drop_mask;
      end
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = (sel == REG_NONE);
      s_nxt.prdata = PWRITE ? 32'h0000_0000 : {24'h00_0000, rd};
    end

    // Access cycle: the write lands at the edge where PREADY is sampled high.
    if (access && PWRITE) begin
      if (sel == REG_GLOBAL_EN) begin
        s_nxt.global_en = PWDATA[7:0] & GLOBAL_EN_VALID;
      end else if (sel == REG_ADD_MASK) begin
        s_nxt.add_mask = PWDATA[7:0] & ADD_MASK_VALID;
      end else if (sel == REG_CH_ADD_MASK) begin
        s_nxt.ch_add_mask = PWDATA[7:0];
      end else if (sel == REG_IRQ_CLEAR) begin
        clr = PWDATA[7:0] & STATUS_VALID;
      end else if (sel == REG_DROP_MASK) begin
        s_nxt.drop_mask = PWDATA[7:0] & DROP_MASK_VALID;
      end
    end

    s_nxt.poll.drop_set = drop_set;
    s_nxt.poll.add_set = add_set;
    s_nxt.poll.prbs_set = prbs_set;

    // Sticky global indications; a new event wins over a clear in the same cycle.
    ev[GIND_DROP_A_BUS_BIT] = GLOBAL_IND.drop_a_bus;
    ev[GIND_DROP_B_BUS_BIT] = GLOBAL_IND.drop_b_bus;
    ev[GIND_ADD_BUS_BIT] = GLOBAL_IND.add_bus;
    ev[GIND_DROP_A_CHAN_BIT] = GLOBAL_IND.drop_a_chan;
    ev[GIND_DROP_B_CHAN_BIT] = GLOBAL_IND.drop_b_chan;
    ev[GIND_ADD_CHAN_BIT] = |(s_r.poll.add_set & s_r.ch_add_mask);
    s_nxt.irq_status = ((s_r.irq_status & ~clr) | ev) & STATUS_VALID;

    s_nxt.irq = s_r.global_en[GEN_IRQ_EN_BIT] &
                (|(s_nxt.irq_status & s_r.global_en & STATUS_VALID));
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_r <= STATE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign PRDATA = s_r.prdata;
  assign PREADY = s_r.pready;
  assign PSLVERR = s_r.pslverr;
  assign POLL_SET = s_r.poll;
  assign IRQ = s_r.irq;

endmodule : cap_top
`default_nettype wire

// file: test/cap_tb_top.sv
// Self-checking bench for the alarm polling mask block.
`timescale 1ns/10ps
`default_nettype none
module cap_tb_top
  import cap_pkg::*;
;
  logic CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [ADDR_W-1:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA;
  logic PREADY, PSLVERR, IRQ;
  cap_drop_evt_t DROP_EVT = '0;
  cap_add_evt_t ADD_EVT = '0;
  logic [NUM_CH-1:0] PRBS_UNLOCK_EVT = '0;
  cap_gind_t GLOBAL_IND = '0;
  cap_poll_t POLL_SET;
  int failures = 0, n_checks = 0, seed = 32'h09F0;
  logic [32:0] rq[$];
  cap_poll_t pq[$];
  cap_poll_t exp_poll;
  logic [7:0] dm, am;
  cap_top i_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .DROP_EVT(DROP_EVT), .ADD_EVT(ADD_EVT), .PRBS_UNLOCK_EVT(PRBS_UNLOCK_EVT),
    .GLOBAL_IND(GLOBAL_IND), .POLL_SET(POLL_SET), .IRQ(IRQ));
  initial forever #5 CLK = ~CLK;
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    n_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d,
      input logic [32:0] e);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= {idx, 2'b00};
    PWDATA <= {24'h0, d};
    rq.push_back(e);
    @(posedge CLK);
    PENABLE <= 1'b1;
    for (int i = 0; i <= 20; i++) begin
      @(posedge CLK);
      if (PREADY === 1'b1) break;
      if (i == 20) failures++;
      if (i == 20) tally_and_finish();
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // One idle edge keeps the release and the next setup out of one time step.
    @(posedge CLK);
  endtask : apb
  function automatic cap_poll_t xp(cap_drop_evt_t d, cap_add_evt_t a, logic [7:0] p);
    xp.drop_set = d.desync_fifo_err & {8{dm[4]}} | d.pointer_ais & {8{dm[3]}}
      | d.pointer_loss & {8{dm[2]}} | d.new_data_flag & {8{dm[1]}} | d.size_mismatch & {8{dm[0]}}
      | d.path_trace_mismatch & {8{am[1]}} | d.path_trace_unlock & {8{am[0]}};
    xp.add_set = a.tx_line_ais & {8{am[6]}} | a.tx_fifo_err & {8{am[5]}}
      | a.tx_signal_loss & {8{am[3]}} | a.tx_clock_loss & {8{am[2]}};
    xp.prbs_set = p & {8{am[4]}};
  endfunction : xp
  task automatic ev;
    logic [63:0] r;
    r = {$random(seed), $random(seed)};
    DROP_EVT <= r[55:0];
    PRBS_UNLOCK_EVT <= r[63:56];
    ADD_EVT <= $random(seed);
    @(posedge CLK);
    pq.push_back(xp(DROP_EVT, ADD_EVT, PRBS_UNLOCK_EVT));
  endtask : ev
  task automatic pulse(input cap_gind_t g, input cap_add_evt_t a, input logic e);
    GLOBAL_IND <= g;
    ADD_EVT <= a;
    @(posedge CLK);
    GLOBAL_IND <= '0;
    ADD_EVT <= '0;
    @(posedge CLK);
    @(negedge CLK);
    chk(33'(IRQ), 33'(e));
    @(posedge CLK);
  endtask : pulse
  always @(posedge CLK)
    if (PSEL && PENABLE && PREADY)
      chk({PSLVERR, PWRITE ? 32'h0 : PRDATA}, rq.pop_front());
  always @(negedge CLK)
    if (pq.size() > 0) begin
      exp_poll = pq.pop_front();
      chk(33'(POLL_SET.drop_set), 33'(exp_poll.drop_set));
      chk(33'(POLL_SET.add_set), 33'(exp_poll.add_set));
      chk(33'(POLL_SET.prbs_set), 33'(exp_poll.prbs_set));
    end
  initial begin
    repeat (16) @(posedge CLK);
    RST <= 1'b0;
    apb(0, IDX_DROP_MASK, 0, 33'h0);
    apb(0, IDX_ADD_MASK, 0, 33'h0);
    apb(1, 12'h001, 8'hFF, {1'b1, 32'h0});
    apb(0, 12'h001, 0, {1'b1, 32'h0});
    $display("test registers done");
    repeat (24) begin
      dm = 8'($random(seed));
      am = 8'($random(seed));
      apb(1, IDX_DROP_MASK, dm, 33'h0);
      apb(1, IDX_ADD_MASK, am, 33'h0);
      apb(0, IDX_DROP_MASK, 0, {25'h0, dm & DROP_MASK_VALID});
      apb(0, IDX_ADD_MASK, 0, {25'h0, am & ADD_MASK_VALID});
      repeat (6) ev();
      DROP_EVT <= '0;
      ADD_EVT <= '0;
      PRBS_UNLOCK_EVT <= '0;
      @(posedge CLK);
    end
    $display("test masks done");
    apb(1, IDX_ADD_MASK, 8'h40, 33'h0);
    apb(1, IDX_CH_ADD_MASK, 8'h80, 33'h0);
    apb(1, IDX_GLOBAL_EN, 8'hA1, 33'h0);
    pulse(5'h10, '0, 1'b1);
    apb(0, IDX_IRQ_STATUS, 0, 33'h20);
    apb(1, IDX_IRQ_CLEAR, 8'h3F, 33'h0);
    pulse('0, 32'h0100_0000, 1'b0);
    pulse('0, 32'h8000_0000, 1'b1);
    apb(0, IDX_IRQ_STATUS, 0, 33'h01);
    apb(1, IDX_IRQ_CLEAR, 8'h3F, 33'h0);
    apb(1, IDX_GLOBAL_EN, 8'h80, 33'h0);
    pulse(5'h10, '0, 1'b0);
    apb(0, IDX_IRQ_STATUS, 0, 33'h20);
    pulse(5'h0F, '0, 1'b0);
    apb(1, IDX_GLOBAL_EN, 8'hFE, 33'h0);
    apb(1, IDX_IRQ_STATUS, 8'h00, 33'h0);
    apb(0, IDX_IRQ_STATUS, 0, 33'h3E);
    apb(0, IDX_GLOBAL_EN, 0, {25'h0, 8'hFE & GLOBAL_EN_VALID});
    apb(0, IDX_CH_ADD_MASK, 0, 33'h80);
    apb(0, IDX_IRQ_CLEAR, 0, 33'h0);
    @(negedge CLK);
    chk(33'(IRQ), 33'h1);
    @(posedge CLK);
    $display("test irq done");
    tally_and_finish();
  end
endmodule : cap_tb_top
bind cap_top cap_top_monitor i_mon (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .DROP_EVT(DROP_EVT), .ADD_EVT(ADD_EVT), .PRBS_UNLOCK_EVT(PRBS_UNLOCK_EVT),
  .GLOBAL_IND(GLOBAL_IND), .POLL_SET(POLL_SET), .IRQ(IRQ));
`default_nettype wire

// file: test/cap_top_monitor.sv
// Port checker for the alarm polling mask block.
`timescale 1ns/10ps
`default_nettype none
module cap_top_monitor
  import cap_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire cap_drop_evt_t DROP_EVT,
  input wire cap_add_evt_t ADD_EVT,
  input wire logic [NUM_CH-1:0] PRBS_UNLOCK_EVT,
  input wire cap_gind_t GLOBAL_IND,
  input wire cap_poll_t POLL_SET,
  input wire logic IRQ
);
  logic [7:0] dm_r, am_r, cm_r, ge_r;
  cap_poll_t x_r;
  logic wr;
  assign wr = PSEL && PENABLE && PREADY && PWRITE;
  // Shadow masks follow the writes; the expected requests use the mask before each edge.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      dm_r <= 8'h00;
      am_r <= 8'h00;
      cm_r <= 8'h00;
      ge_r <= 8'h00;
      x_r <= '0;
    end else begin
      if (wr && PADDR == {IDX_DROP_MASK, 2'b00}) dm_r <= PWDATA[7:0];
      if (wr && PADDR == {IDX_ADD_MASK, 2'b00}) am_r <= PWDATA[7:0];
      if (wr && PADDR == {IDX_CH_ADD_MASK, 2'b00}) cm_r <= PWDATA[7:0];
      if (wr && PADDR == {IDX_GLOBAL_EN, 2'b00}) ge_r <= PWDATA[7:0];
      x_r.drop_set <= DROP_EVT.desync_fifo_err & {8{dm_r[4]}} | DROP_EVT.pointer_ais & {8{dm_r[3]}}
        | DROP_EVT.pointer_loss & {8{dm_r[2]}} | DROP_EVT.new_data_flag & {8{dm_r[1]}}
        | DROP_EVT.size_mismatch & {8{dm_r[0]}} | DROP_EVT.path_trace_mismatch & {8{am_r[1]}}
        | DROP_EVT.path_trace_unlock & {8{am_r[0]}};
      x_r.add_set <= ADD_EVT.tx_line_ais & {8{am_r[6]}} | ADD_EVT.tx_fifo_err & {8{am_r[5]}}
        | ADD_EVT.tx_signal_loss & {8{am_r[3]}} | ADD_EVT.tx_clock_loss & {8{am_r[2]}};
      x_r.prbs_set <= PRBS_UNLOCK_EVT & {8{am_r[4]}};
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  AST_READY_AFTER_SETUP: assert property (s_setup |=> PREADY) else $error("no ready");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY) else $error("ready too long");
  AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY) else $error("stray error");
  AST_RDATA_HIGH_ZERO: assert property (
    PREADY |-> PRDATA[31:8] == 24'h0) else $error("rdata");
  AST_DROP_POLL: assert property (
    POLL_SET.drop_set == x_r.drop_set) else $error("drop");
  AST_ADD_POLL: assert property (
    POLL_SET.add_set == x_r.add_set) else $error("add");
  AST_PRBS_POLL: assert property (POLL_SET.prbs_set == x_r.prbs_set) else $error("prbs");
  AST_IRQ_RAISE: assert property (
    GLOBAL_IND.drop_a_bus && ge_r[7] && ge_r[5] |=> IRQ) else $error("irq");
  AST_IRQ_GATE: assert property (
    !ge_r[7] && !$past(ge_r[7]) |-> !IRQ) else $error("irq gate");
  AST_ADD_CHAN_IRQ: assert property (
    |(POLL_SET.add_set & cm_r) && ge_r[7] && ge_r[0] |=> IRQ) else $error("chan irq");
endmodule : cap_top_monitor
`default_nettype wire
